//--- core/tfp_core.sv
// Summary of operation
// - Fast PWM modes 5,6,7 use TOP 0x00FF/0x01FF/0x03FF; 14 capture, 15 compare A.
// - Fast PWM counts up to TOP, then clears to zero on next timer tick.
// - Fast PWM sets the overflow flag each time the counter reaches TOP.
// - Register TOP in fast PWM sets compare A or capture flag with overflow.
// - Each compare channel sets its flag when counter equals its compare value.
// - Fixed TOP modes zero compare bits above the resolution on every write.
// - Capture-top is unbuffered; if below count, counter runs to 0xFFFF and wraps.
// - Compare A writes go to a buffer, loaded at TOP; in fast PWM with clear and overflow.
// - Output mode 2 gives non-inverted PWM, mode 3 inverted PWM.
// - Fast PWM output changes at match, opposite level at TOP-to-zero step.
// - Compare output reaches the pin only when the pin direction is output.
// - Compare zero gives one-cycle spike in fast PWM, constant level in phase correct; compare equal TOP gives constant level.
// - Output A toggles on each match only with mode 1 and waveform mode 11 or 15.
// - Timer tick is the clock divided by 1, 8, 64, 256 or 1024.
// - Phase correct modes 1,2,3,10,11 count up to TOP then down to zero.
// - Phase correct non-inverting clears on up-match, sets on down-match.
// - Phase correct TOP fixed for modes 1,2,3; capture for 10, compare A for 11.
// - Phase correct counter holds TOP for exactly one timer tick before reversing.
`timescale 1ns/1ps
`include "tfp_defines.svh"

module tfp_core (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // Mode configuration
    input  wire logic [3:0]  waveform_mode_select,
    input  wire logic [2:0]  clock_select,
    input  wire logic [1:0]  compare_a_output_mode,
    input  wire logic [1:0]  compare_b_output_mode,
    // Register writes
    input  wire logic        compare_a_wr,
    input  wire logic        compare_b_wr,
    input  wire logic        capture_top_wr,
    input  wire logic [15:0] wr_data,
    // Flag clears
    input  wire logic        overflow_flag_clr,
    input  wire logic        compare_a_flag_clr,
    input  wire logic        compare_b_flag_clr,
    input  wire logic        capture_flag_clr,
    // Port pin configuration
    input  wire logic        output_pin_direction_a,
    input  wire logic        output_pin_direction_b,
    input  wire logic        port_data_a,
    input  wire logic        port_data_b,
    // Register contents
    output logic      [15:0] counter_value,
    output logic      [15:0] compare_a_value,
    output logic      [15:0] compare_b_value,
    output logic      [15:0] compare_a_buffer,
    output logic      [15:0] capture_top_value,
    // Flags
    output logic             overflow_flag,
    output logic             compare_a_flag,
    output logic             compare_b_flag,
    output logic             capture_flag,
    // Pins
    output logic             compare_a_output_pin,
    output logic             compare_b_output_pin,
    output logic             compare_a_pin_oe,
    output logic             compare_b_pin_oe
);

    // Counting style of a waveform mode
    function automatic tfp_pkg::tfp_kind_t kind_of(input logic [3:0] mode);
        tfp_pkg::tfp_kind_t k;
        case (mode)
            `TFP_WGM_FP_8BIT, `TFP_WGM_FP_9BIT, `TFP_WGM_FP_10BIT,
            `TFP_WGM_FP_CAPT, `TFP_WGM_FP_CMPA: k = tfp_pkg::TFP_KIND_FAST;
            `TFP_WGM_PC_8BIT, `TFP_WGM_PC_9BIT, `TFP_WGM_PC_10BIT,
            `TFP_WGM_PC_CAPT, `TFP_WGM_PC_CMPA: k = tfp_pkg::TFP_KIND_PHASE;
            default: k = tfp_pkg::TFP_KIND_OTHER;
        endcase
        return k;
    endfunction
    // Where TOP comes from in a waveform mode
    function automatic tfp_pkg::tfp_top_src_t top_src_of(input logic [3:0] mode);
        tfp_pkg::tfp_top_src_t s;
        case (mode)
            `TFP_WGM_FP_8BIT, `TFP_WGM_FP_9BIT, `TFP_WGM_FP_10BIT,
            `TFP_WGM_PC_8BIT, `TFP_WGM_PC_9BIT, `TFP_WGM_PC_10BIT:
                s = tfp_pkg::TFP_TOP_FIXED;
            `TFP_WGM_FP_CAPT, `TFP_WGM_PC_CAPT: s = tfp_pkg::TFP_TOP_CAPTURE;
            `TFP_WGM_FP_CMPA, `TFP_WGM_PC_CMPA: s = tfp_pkg::TFP_TOP_COMPARE_A;
            default: s = tfp_pkg::TFP_TOP_NONE;
        endcase
        return s;
    endfunction
    // Fixed TOP value, also the write mask in fixed modes
    function automatic logic [15:0] fixed_top_of(input logic [3:0] mode);
        logic [15:0] t;
        case (mode)
            `TFP_WGM_FP_8BIT, `TFP_WGM_PC_8BIT:   t = `TFP_TOP_8BIT;
            `TFP_WGM_FP_9BIT, `TFP_WGM_PC_9BIT:   t = `TFP_TOP_9BIT;
            `TFP_WGM_FP_10BIT, `TFP_WGM_PC_10BIT: t = `TFP_TOP_10BIT;
            default: t = `TFP_MAX;
        endcase
        return t;
    endfunction
    // Prescaler terminal count for a clock select code
    function automatic logic [9:0] pre_lim_of(input logic [2:0] cs);
        logic [9:0] l;
        case (cs)
            `TFP_CS_DIV8:    l = `TFP_PRE_LIM_8;
            `TFP_CS_DIV64:   l = `TFP_PRE_LIM_64;
            `TFP_CS_DIV256:  l = `TFP_PRE_LIM_256;
            `TFP_CS_DIV1024: l = `TFP_PRE_LIM_1024;
            default:         l = `TFP_PRE_LIM_1;
        endcase
        return l;
    endfunction
    tfp_pkg::tfp_kind_t    kind;
    tfp_pkg::tfp_top_src_t top_src;
    logic [15:0] top_w;
    logic [15:0] wr_mask;
    logic [9:0]  pre_lim;
    logic        pre_run;
    logic        tick;
    logic        at_top;
    logic        at_bottom;
    logic        up_eff;
    logic        top_event;
    logic        load_event;
    logic        ovf_set;
    logic [9:0]  pre_q;
    logic [15:0] cnt_q;
    logic        up_q;
    logic [15:0] icr_q;
    logic [15:0] ocr_q [2];
    logic [15:0] buf_q [2];
    logic        oc_q  [2];
    logic        pin_q [2];
    logic        oe_q  [2];
    logic        ovf_q;
    logic        icf_q;
    logic        ocf_q [2];
    logic [1:0]  com_w  [2];
    logic        wr_w   [2];
    logic        dir_w  [2];
    logic        port_w [2];
    logic        clr_w  [2];
    logic        match  [2];

    // Per channel input grouping
    assign com_w[0]  = compare_a_output_mode;
    assign com_w[1]  = compare_b_output_mode;
    assign wr_w[0]   = compare_a_wr;
    assign wr_w[1]   = compare_b_wr;
    assign dir_w[0]  = output_pin_direction_a;
    assign dir_w[1]  = output_pin_direction_b;
    assign port_w[0] = port_data_a;
    assign port_w[1] = port_data_b;
    assign clr_w[0]  = compare_a_flag_clr;
    assign clr_w[1]  = compare_b_flag_clr;
    // Mode decode and TOP selection
    always_comb begin
        kind    = kind_of(waveform_mode_select);
        top_src = top_src_of(waveform_mode_select);
        wr_mask = fixed_top_of(waveform_mode_select);
        unique case (top_src)
            tfp_pkg::TFP_TOP_FIXED:     top_w = wr_mask;
            tfp_pkg::TFP_TOP_CAPTURE:   top_w = icr_q;
            tfp_pkg::TFP_TOP_COMPARE_A: top_w = ocr_q[0];
            tfp_pkg::TFP_TOP_NONE:      top_w = `TFP_MAX;
        endcase
    end

    // Prescaler tick generation
    assign pre_lim = pre_lim_of(clock_select);
    assign pre_run = (clock_select != `TFP_CS_STOP) && (clock_select <= `TFP_CS_DIV1024);
    assign tick    = pre_run && (pre_q >= pre_lim);
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pre_q <= `TFP_RST_PRE;
        end else if (!pre_run || tick) begin
            pre_q <= `TFP_RST_PRE;
        end else begin
            pre_q <= pre_q + 10'h001;
        end
    end

    // Counter position terms
    assign at_top    = (cnt_q == top_w);
    assign at_bottom = (cnt_q == `TFP_BOTTOM);
    assign up_eff    = at_bottom || (up_q && !at_top);
    assign top_event = tick && at_top && (kind != tfp_pkg::TFP_KIND_OTHER);
    // Compare buffers load at TOP in PWM modes, at once otherwise
    assign load_event = top_event || (kind == tfp_pkg::TFP_KIND_OTHER);
    // Overflow source per counting style
    always_comb begin
        unique case (kind)
            tfp_pkg::TFP_KIND_FAST:  ovf_set = top_event;
            tfp_pkg::TFP_KIND_PHASE: ovf_set = tick && at_bottom && !up_q;
            tfp_pkg::TFP_KIND_OTHER: ovf_set = tick && (cnt_q == `TFP_MAX);
            default:                 ovf_set = 1'b0;
        endcase
    end

    // Counter and direction
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= `TFP_RST_COUNT;
            up_q  <= 1'b1;
        end else if (tick) begin
            unique case (kind)
                tfp_pkg::TFP_KIND_FAST: begin
                    up_q <= 1'b1;
                    if (at_top) begin
                        cnt_q <= `TFP_BOTTOM;
                    end else begin
                        cnt_q <= cnt_q + 16'h0001;
                    end
                end
                tfp_pkg::TFP_KIND_PHASE: begin
                    if (up_q) begin
                        if (at_top) begin
                            cnt_q <= cnt_q - 16'h0001;
                            up_q  <= 1'b0;
                        end else begin
                            cnt_q <= cnt_q + 16'h0001;
                        end
                    end else begin
                        if (at_bottom) begin
                            cnt_q <= cnt_q + 16'h0001;
                            up_q  <= 1'b1;
                        end else begin
                            cnt_q <= cnt_q - 16'h0001;
                        end
                    end
                end
                tfp_pkg::TFP_KIND_OTHER: begin
                    up_q  <= 1'b1;
                    cnt_q <= cnt_q + 16'h0001;
                end
                default: begin
                    up_q  <= 1'b1;
                    cnt_q <= `TFP_RST_COUNT;
                end
            endcase
        end
    end
    // Capture-top register, unbuffered
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            icr_q <= `TFP_RST_CAPTURE;
        end else if (capture_top_wr) begin
            icr_q <= wr_data;
        end
    end

    // Overflow flag, set wins over clear
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ovf_q <= 1'b0;
        end else if (ovf_set) begin
            ovf_q <= 1'b1;
        end else if (overflow_flag_clr) begin
            ovf_q <= 1'b0;
        end
    end
    // Capture flag when capture register defines TOP
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            icf_q <= 1'b0;
        end else if (top_event && (top_src == tfp_pkg::TFP_TOP_CAPTURE)) begin
            icf_q <= 1'b1;
        end else if (capture_flag_clr) begin
            icf_q <= 1'b0;
        end
    end

    // Compare channels
    for (genvar i = 0; i < 2; i++) begin : g_chan
        logic inv;
        logic toggle_ok;
        logic connected;
        logic top_flag;
        assign match[i]  = tick && (cnt_q == ocr_q[i]);
        assign inv       = com_w[i][0];
        assign toggle_ok = (i == 0) && (com_w[i] == `TFP_COM_TOGGLE)
                           && (top_src == tfp_pkg::TFP_TOP_COMPARE_A);
        assign connected = (com_w[i] == `TFP_COM_NONINV) || (com_w[i] == `TFP_COM_INV)
                           || toggle_ok;
        assign top_flag  = (i == 0) && top_event
                           && (top_src == tfp_pkg::TFP_TOP_COMPARE_A);

        // Buffer takes writes anytime, masked in fixed TOP modes
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                buf_q[i] <= `TFP_RST_COMPARE;
            end else if (wr_w[i]) begin
                buf_q[i] <= wr_data & wr_mask;
            end
        end

        // Active compare value loads from buffer
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                ocr_q[i] <= `TFP_RST_COMPARE;
            end else if (load_event) begin
                ocr_q[i] <= buf_q[i];
            end
        end

        // Compare flag, set wins over clear
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                ocf_q[i] <= 1'b0;
            end else if (match[i] || top_flag) begin
                ocf_q[i] <= 1'b1;
            end else if (clr_w[i]) begin
                ocf_q[i] <= 1'b0;
            end
        end

        // Waveform output level
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                oc_q[i] <= 1'b0;
            end else if (toggle_ok && match[i]) begin
                oc_q[i] <= !oc_q[i];
            end else if (kind == tfp_pkg::TFP_KIND_FAST && !toggle_ok && connected) begin
                if (top_event) begin
                    oc_q[i] <= !inv;
                end else if (match[i]) begin
                    oc_q[i] <= inv;
                end
            end else if (kind == tfp_pkg::TFP_KIND_PHASE && !toggle_ok && connected) begin
                if (match[i]) begin
                    oc_q[i] <= up_eff ? inv : !inv;
                end
            end
        end

        // Pin drive follows direction and output mode
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                pin_q[i] <= 1'b0;
                oe_q[i]  <= 1'b0;
            end else begin
                pin_q[i] <= connected ? oc_q[i] : port_w[i];
                oe_q[i]  <= dir_w[i];
            end
        end
    end
    // Output assignment
    assign counter_value        = cnt_q;
    assign compare_a_value      = ocr_q[0];
    assign compare_b_value      = ocr_q[1];
    assign compare_a_buffer     = buf_q[0];
    assign capture_top_value    = icr_q;
    assign overflow_flag        = ovf_q;
    assign compare_a_flag       = ocf_q[0];
    assign compare_b_flag       = ocf_q[1];
    assign capture_flag         = icf_q;
    assign compare_a_output_pin = pin_q[0];
    assign compare_b_output_pin = pin_q[1];
    assign compare_a_pin_oe     = oe_q[0];
    assign compare_b_pin_oe     = oe_q[1];
endmodule

//--- core/tfp_defines.svh
`ifndef TFP_DEFINES_SVH
`define TFP_DEFINES_SVH

// Counter extremes and fixed TOP values
`define TFP_BOTTOM        16'h0000
`define TFP_MAX           16'hffff
`define TFP_TOP_8BIT      16'h00ff
`define TFP_TOP_9BIT      16'h01ff
`define TFP_TOP_10BIT     16'h03ff

// Waveform mode codes handled here
`define TFP_WGM_PC_8BIT   4'h1
`define TFP_WGM_PC_9BIT   4'h2
`define TFP_WGM_PC_10BIT  4'h3
`define TFP_WGM_FP_8BIT   4'h5
`define TFP_WGM_FP_9BIT   4'h6
`define TFP_WGM_FP_10BIT  4'h7
`define TFP_WGM_PC_CAPT   4'ha
`define TFP_WGM_PC_CMPA   4'hb
`define TFP_WGM_FP_CAPT   4'he
`define TFP_WGM_FP_CMPA   4'hf

// Compare output mode codes
`define TFP_COM_OFF       2'h0
`define TFP_COM_TOGGLE    2'h1
`define TFP_COM_NONINV    2'h2
`define TFP_COM_INV       2'h3

// Clock select codes
`define TFP_CS_STOP       3'h0
`define TFP_CS_DIV1       3'h1
`define TFP_CS_DIV8       3'h2
`define TFP_CS_DIV64      3'h3
`define TFP_CS_DIV256     3'h4
`define TFP_CS_DIV1024    3'h5

// Prescaler terminal counts (divisor minus one)
`define TFP_PRE_LIM_1     10'h000
`define TFP_PRE_LIM_8     10'h007
`define TFP_PRE_LIM_64    10'h03f
`define TFP_PRE_LIM_256   10'h0ff
`define TFP_PRE_LIM_1024  10'h3ff

// Reset values
`define TFP_RST_COUNT     16'h0000
`define TFP_RST_COMPARE   16'h0000
`define TFP_RST_CAPTURE   16'h0000
`define TFP_RST_PRE       10'h000

`endif

//--- core/tfp_pkg.sv
package tfp_pkg;

    // Counting style selected by the waveform mode
    typedef enum logic [1:0] {
        TFP_KIND_OTHER,
        TFP_KIND_FAST,
        TFP_KIND_PHASE
    } tfp_kind_t;

    // Source of the TOP value
    typedef enum logic [1:0] {
        TFP_TOP_FIXED,
        TFP_TOP_CAPTURE,
        TFP_TOP_COMPARE_A,
        TFP_TOP_NONE
    } tfp_top_src_t;

endpackage

//--- testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic        clk, arst_n, clr;
    logic [3:0]  waveform_mode_select;
    logic [2:0]  clock_select;
    logic [1:0]  compare_a_output_mode, compare_b_output_mode;
    logic        compare_a_wr, compare_b_wr, capture_top_wr;
    logic [15:0] wr_data;
    logic        overflow_flag_clr, compare_a_flag_clr, compare_b_flag_clr, capture_flag_clr;
    logic        output_pin_direction_a, output_pin_direction_b, port_data_a, port_data_b;
    logic [15:0] counter_value, compare_a_value, compare_b_value, compare_a_buffer;
    logic [15:0] capture_top_value;
    logic        overflow_flag, compare_a_flag, compare_b_flag, capture_flag;
    logic        compare_a_output_pin, compare_b_output_pin, compare_a_pin_oe, compare_b_pin_oe;
    logic        level_a, level_b;
    int          high_a, high_b, err_total, checks_done;
    logic [3:0]  modes [10] = '{4'h5, 4'h6, 4'h7, 4'he, 4'hf, 4'h1, 4'h2, 4'h3, 4'ha, 4'hb};
    logic [15:0] tops [10] = '{16'h00ff, 16'h01ff, 16'h03ff, 16'h0005, 16'h0006,
                               16'h00ff, 16'h01ff, 16'h03ff, 16'h0005, 16'h0006};
    int          divs [5] = '{1, 8, 64, 256, 1024};

    // Device and pin loads
    tfp_core i_dut (.clk, .arst_n, .waveform_mode_select, .clock_select, .compare_a_output_mode,
        .compare_b_output_mode, .compare_a_wr, .compare_b_wr, .capture_top_wr, .wr_data,
        .overflow_flag_clr, .compare_a_flag_clr, .compare_b_flag_clr, .capture_flag_clr,
        .output_pin_direction_a, .output_pin_direction_b, .port_data_a, .port_data_b,
        .counter_value, .compare_a_value, .compare_b_value, .compare_a_buffer,
        .capture_top_value, .overflow_flag, .compare_a_flag, .compare_b_flag, .capture_flag,
        .compare_a_output_pin, .compare_b_output_pin, .compare_a_pin_oe, .compare_b_pin_oe);
    tfp_load i_load_a (.clk, .clr, .pin(compare_a_output_pin), .oe(compare_a_pin_oe),
        .level(level_a), .high_cnt(high_a));
    tfp_load i_load_b (.clk, .clr, .pin(compare_b_output_pin), .oe(compare_b_pin_oe),
        .level(level_b), .high_cnt(high_b));

    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Edges, then drive just after
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Compare and count
    task automatic chk(input string what, input logic [15:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One write strobe: 0 compare A, 1 compare B, 2 capture top
    task automatic wr(input int sel, input logic [15:0] d);
        wr_data = d;
        compare_a_wr = sel == 0;
        compare_b_wr = sel == 1;
        capture_top_wr = sel == 2;
        step(1);
        {compare_a_wr, compare_b_wr, capture_top_wr} = 3'h0;
        step(1);
    endtask

    // Reset with mode and prescaler chosen
    task automatic start(input logic [3:0] m, input logic [2:0] cs);
        arst_n = 1'b0;
        waveform_mode_select = m;
        clock_select = cs;
        step(6);
        arst_n = 1'b1;
    endtask

    // Bounded wait for a count
    task automatic wait_cnt(input logic [15:0] v);
        int i;
        i = 0;
        while (counter_value !== v && i < 5000) begin
            step(1);
            i++;
        end
        chk("counter reach", counter_value, v);
    endtask

    // Measure high time over n cycles
    task automatic meas(input int n);
        clr = 1'b1;
        step(1);
        clr = 1'b0;
        step(n);
    endtask

    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // Hang guard
    initial begin
        #100000;
        err_total++;
        report_and_stop();
    end

    // Test sequence
    initial begin
        {clr, compare_a_wr, compare_b_wr, capture_top_wr, wr_data} = '0;
        {overflow_flag_clr, compare_a_flag_clr, compare_b_flag_clr, capture_flag_clr} = 4'h0;
        {port_data_a, port_data_b, compare_a_output_mode, compare_b_output_mode} = '0;
        {output_pin_direction_a, output_pin_direction_b} = 2'h3;
        {err_total, checks_done} = '0;
        for (int k = 0; k < 10; k++) begin
            start(4'h0, 3'h1);
            wr(2, 16'h0005);
            wr(0, 16'h0006);
            waveform_mode_select = modes[k];
            wait_cnt(tops[k]);
            step(1);
            chk("after top", counter_value, k < 5 ? 16'h0000 : tops[k] - 16'h0001);
        end
        $display("test top table done");
        for (int k = 0; k < 5; k++) begin
            start(4'h5, 3'(k + 1));
            wait_cnt(16'h0001);
            step(divs[k]);
            chk("prescaled count", counter_value, 16'h0002);
        end
        $display("test prescaler done");
        compare_a_output_mode = 2'h2;
        compare_b_output_mode = 2'h3;
        start(4'h5, 3'h1);
        wr(0, 16'h1240);
        chk("masked buffer", compare_a_buffer, 16'h0040);
        wr(1, 16'h00ff);
        step(600);
        meas(256);
        chk("duty a", 16'(high_a), 16'h0041);
        chk("level b", 16'(high_b), 16'h0000);
        chk("flags", {12'h0, overflow_flag, compare_a_flag, compare_b_flag, capture_flag},
            16'h000e);
        wait_cnt(16'h0010);
        {overflow_flag_clr, compare_a_flag_clr, compare_b_flag_clr, capture_flag_clr} = 4'hf;
        step(1);
        {overflow_flag_clr, compare_a_flag_clr, compare_b_flag_clr, capture_flag_clr} = 4'h0;
        chk("cleared", {12'h0, overflow_flag, compare_a_flag, compare_b_flag, capture_flag},
            16'h0000);
        compare_b_output_mode = 2'h0;
        port_data_b = 1'b1;
        output_pin_direction_a = 1'b0;
        meas(20);
        chk("port data b", 16'(high_b), 16'h0014);
        chk("pin a off", 16'(high_a), 16'h0000);
        output_pin_direction_a = 1'b1;
        $display("test fast output done");
        start(4'he, 3'h1);
        wr(2, 16'h0003);
        step(20);
        meas(40);
        chk("spike", 16'(high_a), 16'h000a);
        chk("capture flag", {15'h0, capture_flag}, 16'h0001);
        wr(2, 16'h0100);
        wait_cnt(16'h0080);
        wr(2, 16'h0002);
        step(200);
        chk("missed top", 16'(counter_value > 16'h0100), 16'h0001);
        $display("test capture top done");
        compare_a_output_mode = 2'h1;
        start(4'hf, 3'h1);
        wr(0, 16'h0009);
        step(40);
        meas(20);
        chk("toggle duty", 16'(high_a), 16'h000a);
        wait_cnt(16'h0001);
        wr(0, 16'h0013);
        chk("value held", compare_a_value, 16'h0009);
        wait_cnt(16'h0000);
        chk("value loaded", compare_a_value, 16'h0013);
        $display("test toggle done");
        compare_a_output_mode = 2'h2;
        compare_b_output_mode = 2'h3;
        start(4'h1, 3'h1);
        wr(0, 16'h0080);
        wr(1, 16'h0080);
        step(1100);
        meas(510);
        chk("phase duty a", 16'(high_a), 16'h0100);
        chk("phase duty b", 16'(high_b), 16'h00fe);
        $display("test phase output done");
        report_and_stop();
    end
endmodule

//--- testbench/tfp_core_chk.sv
`timescale 1ns/1ps
module tfp_chk (
    // Clock and reset
    input wire logic        clk,
    input wire logic        arst_n,
    // Controls
    input wire logic [3:0]  waveform_mode_select,
    input wire logic [2:0]  clock_select,
    input wire logic [1:0]  compare_a_output_mode,
    input wire logic        compare_a_wr,
    input wire logic        capture_top_wr,
    input wire logic [15:0] wr_data,
    input wire logic        output_pin_direction_a,
    // Timer state
    input wire logic [15:0] counter_value,
    input wire logic [15:0] compare_a_value,
    input wire logic [15:0] compare_b_value,
    input wire logic [15:0] compare_a_buffer,
    input wire logic [15:0] capture_top_value,
    input wire logic        overflow_flag,
    input wire logic        compare_a_flag,
    input wire logic        compare_b_flag,
    input wire logic        capture_flag,
    input wire logic        compare_a_output_pin,
    input wire logic        compare_a_pin_oe
);
    logic [3:0]  m;
    logic        tk;
    logic        fast;
    logic        phase;
    logic [15:0] msk;
    logic [15:0] top;

    // Mode decode, write mask and active TOP
    assign m = waveform_mode_select;
    assign tk = clock_select == 3'h1;
    assign fast = m inside {4'h5, 4'h6, 4'h7, 4'he, 4'hf};
    assign phase = m inside {4'h1, 4'h2, 4'h3, 4'ha, 4'hb};
    assign msk = (m == 4'h1 || m == 4'h5) ? 16'h00ff : (m == 4'h2 || m == 4'h6) ? 16'h01ff
               : (m == 4'h3 || m == 4'h7) ? 16'h03ff : 16'hffff;
    assign top = (m == 4'ha || m == 4'he) ? capture_top_value
               : (m == 4'hb || m == 4'hf) ? compare_a_value : msk;

    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);

    // Pin follows the internal level two edges after the event
    sequence s_pin(lvl);
        ##2 compare_a_output_pin == lvl;
    endsequence

    a_fast_wrap: assert property (
        tk && fast && counter_value == top |=> counter_value == 16'h0000 && overflow_flag)
        else $error("fast mode did not wrap with overflow");
    a_fast_count: assert property (
        tk && fast && counter_value != top |=> counter_value == $past(counter_value) + 16'h0001)
        else $error("fast mode count step wrong");
    a_cmpa_top_flag: assert property (
        tk && m == 4'hf && counter_value == compare_a_value |=> compare_a_flag && overflow_flag)
        else $error("compare A flag not set with overflow");
    a_capt_top_flag: assert property (
        tk && m == 4'he && counter_value == capture_top_value |=> capture_flag && overflow_flag)
        else $error("capture flag not set with overflow");
    a_cmpb_flag_set: assert property (
        tk && (fast || phase) && counter_value == compare_b_value |=> compare_b_flag)
        else $error("compare B flag not set on match");
    a_buffer_load: assert property (
        tk && fast && counter_value == top |=> compare_a_value == $past(compare_a_buffer))
        else $error("compare A not loaded at TOP");
    a_mask_write: assert property (
        compare_a_wr |=> compare_a_buffer == ($past(wr_data) & $past(msk)))
        else $error("compare write not masked");
    a_capt_write: assert property (
        capture_top_wr |=> capture_top_value == $past(wr_data))
        else $error("capture top not taken at once");
    a_pin_enable: assert property (
        output_pin_direction_a ##1 output_pin_direction_a |=> compare_a_pin_oe)
        else $error("pin not enabled as output");
    a_fast_match: assert property (
        tk && fast && compare_a_output_mode[1] && counter_value == compare_a_value
        && counter_value != top |-> s_pin(compare_a_output_mode[0]))
        else $error("fast output wrong after match");
    a_fast_bottom: assert property (
        tk && fast && compare_a_output_mode[1] && counter_value == top
        |-> s_pin(!compare_a_output_mode[0]))
        else $error("fast output wrong at bottom");
    a_toggle_out: assert property (
        tk && m == 4'hf && compare_a_output_mode == 2'h1 && counter_value == compare_a_value
        |-> ##2 compare_a_output_pin != $past(compare_a_output_pin))
        else $error("output A did not toggle");
    a_phase_turn: assert property (
        tk && phase && counter_value == top && top != 16'h0000
        |=> counter_value == $past(counter_value) - 16'h0001)
        else $error("phase counter did not turn at TOP");
    a_phase_up: assert property (
        tk && phase && compare_a_output_mode[1] && counter_value == compare_a_value
        && counter_value > $past(counter_value) && counter_value != top
        |-> s_pin(compare_a_output_mode[0]))
        else $error("phase output wrong on up match");
endmodule

bind tfp_core tfp_chk u_chk (.clk, .arst_n, .waveform_mode_select, .clock_select,
    .compare_a_output_mode, .compare_a_wr, .capture_top_wr, .wr_data, .output_pin_direction_a,
    .counter_value, .compare_a_value, .compare_b_value, .compare_a_buffer, .capture_top_value,
    .overflow_flag, .compare_a_flag, .compare_b_flag, .capture_flag, .compare_a_output_pin,
    .compare_a_pin_oe);

//--- testbench/tfp_load.sv
`timescale 1ns/1ps
module tfp_load (
    // Clock and window clear
    input  wire logic clk,
    input  wire logic clr,
    // Pin as driven
    input  wire logic pin,
    input  wire logic oe,
    // Load view
    output logic      level,
    output int        high_cnt
);
    // Pull-down keeps the node low when undriven
    assign level = oe ? pin : 1'b0;

    // High time over the window
    always_ff @(posedge clk) begin
        high_cnt <= clr ? 0 : high_cnt + int'(level);
    end
endmodule
